// ### verilog/shc_defs.svh
// constants for the standby halt control block
`ifndef SHC_DEFS_SVH
`define SHC_DEFS_SVH
`define SHC_PC_W 10
`define SHC_PC_RESTART 10'h000
`define SHC_SYNC_W 3
`endif

// ### verilog/shc_pkg.sv
// types for the standby halt control block
package shc_pkg;
   typedef enum logic [2:0] {
      SHC_RUN = 3'b001,
      SHC_HALT = 3'b010,
      SHC_RESUME = 3'b100
   } shc_state_type;
endpackage : shc_pkg

// ### verilog/shc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "shc_defs.svh"
module shc_pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin and filtered level
   input wire logic pin,
   output logic level
);
   logic [`SHC_SYNC_W-1:0] stage;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage <= {`SHC_SYNC_W{RESET_LEVEL}};
      end else begin
         stage <= {stage[`SHC_SYNC_W-2:0], pin};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         level <= RESET_LEVEL;
      end else if (stage[1] == stage[2]) begin
         level <= stage[2];
      end
   end
endmodule : shc_pin_sync

// ### verilog/shc_standby_halt_control.sv
// standby halt control: halt entry, exit and restart of the core
//
// Notes on behaviour
// - halt entered only if control pin high
// - reset pin low ends halt
// - control pin low ends halt, RC only
// - after reset, program counter restarts at zero
// - registers kept unchanged while halted
// - operation suspended while halted
`timescale 1ns/1ps
`include "shc_defs.svh"
module shc_standby_halt_control
   import shc_pkg::*;
#(
   parameter logic RC_OSC = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins
   input wire logic standbyControlPin,
   input wire logic reset_input_n,
   // core side
   input wire logic haltInstr,
   // to core
   output logic coreRun,
   output logic coreReset,
   output logic regHold,
   output logic [`SHC_PC_W-1:0] pcLoad,
   output logic pcLoadValid,
   output shc_pkg::shc_state_type state
);
   import shc_pkg::*;

   // -------------------------------
   // internal signals
   // -------------------------------
   // filtered control pin level
   logic ctrlLevel;
   // filtered reset pin level
   logic resetLevelN;
   // any condition that ends halt
   logic exitReq;
   // halt instruction accepted
   logic haltTake;
   // restart of the core due
   logic restartReq;
   // raw pins, control first
   logic [1:0] pinRaw;
   // filtered pins, control first
   logic [1:0] pinLevel;

   // -------------------------------
   // decode helpers
   // -------------------------------
   // halt accepted: running, control high, no reset
   function automatic logic halt_taken(
      input shc_state_type cur,
      input logic instr,
      input logic ctrl,
      input logic resN
   );
      halt_taken = (cur == SHC_RUN) && instr && ctrl && resN;
   endfunction : halt_taken

   // restart: reset pin low, or halt left
   function automatic logic restart_due(
      input shc_state_type cur,
      input logic exitNow,
      input logic resN
   );
      restart_due = !resN || ((cur == SHC_HALT) && exitNow);
   endfunction : restart_due

   // -------------------------------
   // pin synchronisers
   // -------------------------------
   assign pinRaw = {reset_input_n, standbyControlPin};

   // both pins held low through reset
   generate
      for (genvar i = 0; i < 2; i++) begin : g_sync
         shc_pin_sync #(.RESET_LEVEL(1'b0)) u_sync (
            .clk(clk),
            .rst(rst),
            .pin(pinRaw[i]),
            .level(pinLevel[i])
         );
      end
   endgenerate

   assign ctrlLevel = pinLevel[0];
   assign resetLevelN = pinLevel[1];

   // -------------------------------
   // request decode
   // -------------------------------
   // ctrl exit honoured only with RC oscillator
   assign exitReq = !resetLevelN || (RC_OSC && !ctrlLevel);

   // halt with control low is dropped
   assign haltTake = halt_taken(state, haltInstr, ctrlLevel, resetLevelN);

   // every halt exit restarts the core
   assign restartReq = restart_due(state, exitReq, resetLevelN);

   // -------------------------------
   // halt state machine
   // -------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= SHC_RESUME;
      end else if (!resetLevelN) begin
         state <= SHC_RESUME;
      end else begin
         unique case (state)
            SHC_RUN: begin
               // halt only with control high, else no effect
               if (haltTake) begin
                  state <= SHC_HALT;
               end
            end
            SHC_HALT: begin
               if (exitReq) begin
                  state <= SHC_RESUME;
               end
            end
            SHC_RESUME: begin
               state <= SHC_RUN;
            end
            default: begin
               state <= SHC_RESUME;
            end
         endcase
      end
   end

   // -------------------------------
   // core run enable
   // -------------------------------
   // drops in the cycle halt is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         coreRun <= 1'b0;
      end else begin
         coreRun <= (state == SHC_RUN) && !haltTake && resetLevelN;
      end
   end

   // -------------------------------
   // register freeze
   // -------------------------------
   // held from halt entry until exit
   always_ff @(posedge clk) begin
      if (rst) begin
         regHold <= 1'b0;
      end else if (state == SHC_RUN) begin
         regHold <= haltTake;
      end else begin
         regHold <= (state == SHC_HALT) && !exitReq;
      end
   end

   // -------------------------------
   // core reset
   // -------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         coreReset <= 1'b1;
      end else begin
         coreReset <= restartReq;
      end
   end

   // -------------------------------
   // program counter restart
   // -------------------------------
   // restart address is fixed
   always_ff @(posedge clk) begin
      if (rst) begin
         pcLoad <= `SHC_PC_RESTART;
      end else begin
         pcLoad <= `SHC_PC_RESTART;
      end
   end

   // load strobe with every restart
   always_ff @(posedge clk) begin
      if (rst) begin
         pcLoadValid <= 1'b1;
      end else begin
         pcLoadValid <= restartReq;
      end
   end
endmodule : shc_standby_halt_control

// ### sim/shc_monitor.sv
// checker of standby halt control ports
`timescale 1ns/1ps
module shc_monitor import shc_pkg::*; (
   input wire logic clk, rst, standbyControlPin, reset_input_n, haltInstr,
   input wire logic coreRun, coreReset, regHold, pcLoadValid,
   input wire logic [9:0] pcLoad,
   input wire shc_state_type state
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_TAKE: assert property (
      (standbyControlPin && reset_input_n) [*6] ##0 (haltInstr && state == SHC_RUN)
      |=> state == SHC_HALT) else $error("halt not taken");
   AST_RESX: assert property (
      !reset_input_n [*8] |-> state != SHC_HALT) else $error("reset pin ignored");
   AST_CTLX: assert property (
      !standbyControlPin [*8] |-> state != SHC_HALT) else $error("control exit ignored");
   AST_PC0: assert property (
      state == SHC_RESUME |-> coreReset && pcLoadValid && pcLoad == 10'h000)
      else $error("bad restart");
   AST_HOLD: assert property (
      state == SHC_HALT |-> regHold) else $error("registers not held");
   AST_STOP: assert property (
      state == SHC_HALT |-> !coreRun) else $error("core still running");
   AST_NOP: assert property (
      (!standbyControlPin && reset_input_n) [*6] ##0 (haltInstr && state == SHC_RUN)
      |=> state == SHC_RUN)
      else $error("halt not ignored");
endmodule : shc_monitor
bind shc_standby_halt_control shc_monitor mon (.clk, .rst, .standbyControlPin,
   .reset_input_n, .haltInstr, .coreRun, .coreReset, .regHold, .pcLoadValid, .pcLoad,
   .state);

// ### sim/shc_power_model.sv
// external power fail detection and reset circuit
`timescale 1ns/1ps
module shc_power_model (
   input wire logic clk, ctrlReq, resReq,
   output logic standbyControlPin = 1'b1,
   output logic reset_input_n = 1'b1
);
   // pins follow the requests on every rising clock edge, without regard to the halt instruction
   always @(posedge clk) begin
      standbyControlPin <= ctrlReq;
      reset_input_n <= !resReq;
   end
endmodule : shc_power_model

// ### sim/tb_top.sv
// bench for standby halt control
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
   import shc_pkg::*;
   logic clk = 0, rst = 1, ctrlReq = 1, resReq = 0, haltInstr = 0;
   logic standbyControlPin, reset_input_n, coreRun, coreReset, regHold, pcLoadValid;
   logic [9:0] pcLoad;
   shc_state_type state;
   int miscompares = 0, checks_done = 0, cyc = 0;
   always #50 clk = !clk;
   shc_power_model pwr (.clk, .ctrlReq, .resReq, .standbyControlPin, .reset_input_n);
   shc_standby_halt_control dut (.clk, .rst, .standbyControlPin, .reset_input_n,
      .haltInstr, .coreRun, .coreReset, .regHold, .pcLoad, .pcLoadValid, .state);
   task automatic wait_n(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_n
   task automatic halt_now();
      @(posedge clk) haltInstr <= 1'b1;
      @(posedge clk) haltInstr <= 1'b0;
      #1;
   endtask : halt_now
   task automatic t_nop();
      @(posedge clk) ctrlReq <= 1'b0;
      wait_n(8);
      halt_now();
      `CHK(state, SHC_RUN)
      `CHK(coreRun, 1'b1)
      @(posedge clk) ctrlReq <= 1'b1;
      wait_n(8);
      $display("nop test done");
   endtask : t_nop
   task automatic t_exit(logic byPin);
      halt_now();
      `CHK(state, SHC_HALT)
      wait_n(8);
      `CHK(regHold, 1'b1)
      `CHK(coreRun, 1'b0)
      @(posedge clk) if (byPin) ctrlReq <= 1'b0; else resReq <= 1'b1;
      wait_n(10);
      `CHK(state == SHC_HALT, 1'b0)
      `CHK(pcLoad, 10'h000)
      `CHK(coreReset, !byPin)
      `CHK(pcLoadValid, !byPin)
      @(posedge clk) ctrlReq <= 1'b1;
      resReq <= 1'b0;
      wait_n(10);
      `CHK(state, SHC_RUN)
      `CHK(coreReset, 1'b0)
      `CHK(coreRun, 1'b1)
      $display("exit test done");
   endtask : t_exit
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wait_n(8);
      t_nop();
      t_exit(1'b0);
      t_exit(1'b1);
      report_and_stop();
   end
endmodule : tb_top
